// ### hdl/pmcp_mode_change.sv
module pmcp_mode_change
  import pmcp_pkg::*;
#(
  parameter int unsigned NPORT        = 4,
  parameter int unsigned NPART        = 4,
  parameter int unsigned LAT_NONE_CYC = pmcp_pkg::LAT_NONE,
  parameter int unsigned LAT_RST_CYC  = pmcp_pkg::LAT_RST
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic [NPORT-1:0]     ts1_hot_reset,
  input  wire logic [NPORT-1:0]     dl_down,
  input  wire logic [NPORT-1:0]     rx_l0s_exit,
  input  wire logic [NPORT-1:0]     in_l1,
  input  wire logic [NPORT-1:0]     pme_sync_busy,
  input  wire logic [NPORT-1:0]     pme_ack_all,
  input  wire logic [NPORT-1:0]     pme_abandon,
  input  wire logic [NPORT-1:0]     pme_ack_seen,
  input  wire logic [NPORT-1:0]     pme_ack_timeout,
  input  wire logic [4*NPORT-1:0]   intx_in,
  input  wire logic [NPORT-1:0]     secondary_reset_bit,
  input  wire logic [NPORT-1:0]     lock_set,
  input  wire logic [NPART-1:0]     lock_release,
  output logic [NPORT-1:0]          port_in_reset,
  output logic [NPORT-1:0]          route_valid,
  output logic [NPORT-1:0]          l0s_exit_req,
  output logic [NPORT-1:0]          l1_entry_ok,
  output logic [NPORT-1:0]          pme_member,
  output logic [4*NPORT-1:0]        intx_up,
  output logic [NPORT-1:0]          port_act_reset,
  output logic [DEV_W*NPORT-1:0]    dev_num,
  output logic [NPART-1:0]          part_hot_reset,
  output logic [NPART-1:0]          part_sbr,
  output logic [NPART-1:0]          part_locked
);
  import pmcp_pkg::*;

  localparam int unsigned IW = $clog2(NPORT);
  localparam int unsigned SW = NSYNC * NPORT;

  // ****************************************
  // link input synchronisers
  // ****************************************
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  wire  [SW-1:0] raw = {intx_in, pme_ack_timeout, pme_ack_seen, pme_abandon, pme_ack_all,
                        pme_sync_busy, in_l1, rx_l0s_exit, dl_down, ts1_hot_reset};

  always_ff @(posedge clk) begin
    s1_r <= sys_rst ? '0 : raw;
    s2_r <= sys_rst ? '0 : s1_r;
  end

  wire [NPORT-1:0]   hot_s  = s2_r[0*NPORT +: NPORT];
  wire [NPORT-1:0]   dld_s  = s2_r[1*NPORT +: NPORT];
  wire [NPORT-1:0]   rxx_s  = s2_r[2*NPORT +: NPORT];
  wire [NPORT-1:0]   l1_s   = s2_r[3*NPORT +: NPORT];
  wire [NPORT-1:0]   psb_s  = s2_r[4*NPORT +: NPORT];
  wire [NPORT-1:0]   pall_s = s2_r[5*NPORT +: NPORT];
  wire [NPORT-1:0]   pab_s  = s2_r[6*NPORT +: NPORT];
  wire [NPORT-1:0]   pseen_s = s2_r[7*NPORT +: NPORT];
  wire [NPORT-1:0]   pto_s  = s2_r[8*NPORT +: NPORT];
  wire [4*NPORT-1:0] intx_s = s2_r[9*NPORT +: 4*NPORT];

  // ****************************************
  // register state
  // ****************************************
  logic [31:0]       ctl_r [NPORT];
  logic [NPORT-1:0]  started_r;
  logic [NPORT-1:0]  done_r;
  logic [NPORT-1:0]  pend_r;
  logic [NPORT-1:0]  att_r;
  pmcp_mode_t        mode_r [NPORT];
  logic [PSEL_W-1:0] part_r [NPORT];
  logic [DEV_W-1:0]  device_number_field_r [NPORT];
  logic [NPORT-1:0]  lock_port_r;
  logic [NPART-1:0]  lock_r;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic          wr_r;
  logic          wr_sts_r;
  logic [IW-1:0] wr_idx_r;

  wire          ahb_go = hsel & htrans[1] & hready;
  wire          a_hit  = (haddr[31:3] < 29'(NPORT)) && (haddr[1:0] == 2'h0)
                         && (hsize == HSIZE_WORD);
  wire [IW-1:0] a_idx  = haddr[3 +: IW];
  wire          a_sts  = haddr[2];
  wire [31:0]   sts_word = {29'h0, pend_r[a_idx] | busy_of(a_idx),
                            done_r[a_idx], started_r[a_idx]};
  wire [31:0]   rd_word  = !a_hit ? 32'h0 : a_sts ? sts_word : ctl_r[a_idx];

  wire          wr_ctl = wr_r & ~wr_sts_r;
  wire          wr_st  = wr_r & wr_sts_r;
  wire [31:0]   old_ctl = ctl_r[wr_idx_r];
  // rewriting the same routing fields must not start a change
  wire          ctl_diff = (hwdata[MODE_LSB +: MODE_W] != old_ctl[MODE_LSB +: MODE_W])
                         | (hwdata[PSEL_LSB +: PSEL_W] != old_ctl[PSEL_LSB +: PSEL_W])
                         | (hwdata[DEV_LSB +: DEV_W] != old_ctl[DEV_LSB +: DEV_W]);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_r     <= 1'b0;
      wr_sts_r <= 1'b0;
      wr_idx_r <= '0;
    end else begin
      wr_r     <= ahb_go & hwrite & a_hit;
      wr_sts_r <= a_sts;
      wr_idx_r <= a_idx;
    end
  end

  always_ff @(posedge clk) begin
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
    // loaded at the address edge so it stands in the zero-wait data phase
    hrdata    <= (ahb_go & ~hwrite) ? rd_word : 32'h0;
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0;
    end
  end

  // ****************************************
  // change sequencer
  // ****************************************
  pmcp_state_t        state_r;
  logic [IW-1:0]      cur_r;
  logic               act_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [IW-1:0]      pick;

  function automatic logic busy_of(input logic [IW-1:0] idx);
    busy_of = (state_r != S_IDLE) && (cur_r == idx);
  endfunction

  always_comb begin
    pick = '0;
    for (int k = NPORT - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        pick = IW'(k);
      end
    end
  end

  wire [31:0]      cur_ctl  = ctl_r[cur_r];
  wire             cur_att  = att_r[cur_r];
  wire             cur_up   = cur_att & (mode_r[cur_r] == PMCP_UP);
  wire             cur_dn   = cur_att & (mode_r[cur_r] == PMCP_DOWN);
  wire             pme_fin  = (cur_up & (pall_s[cur_r] | pab_s[cur_r]))
                            | (cur_dn & (pseen_s[cur_r] | pto_s[cur_r]));
  wire             pme_clear = ~cur_att | ~psb_s[cur_r] | pme_fin;
  wire [CNT_W-1:0] act_len  = act_r ? CNT_W'(LAT_RST_CYC - LAT_MARGIN)
                                    : CNT_W'(LAT_NONE_CYC - LAT_MARGIN);
  wire pmcp_mode_t new_mode = pmcp_mode_t'(cur_ctl[MODE_LSB +: MODE_W]);
  wire [PSEL_W-1:0] new_part = cur_ctl[PSEL_LSB +: PSEL_W];
  wire             new_att  = ((new_mode == PMCP_UP) | (new_mode == PMCP_DOWN))
                            & (32'(new_part) < NPART);
  wire             take     = (state_r == S_IDLE) & (|pend_r);
  wire             removing = (state_r == S_REMOVE);

  // every change, same partition or not, detaches, then re-attaches only when the new mode is up or down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      cur_r   <= '0;
      act_r   <= 1'b0;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (|pend_r) begin
            cur_r   <= pick;
            act_r   <= ctl_r[pick][ACT_BIT];
            state_r <= S_PME;
          end
        end
        S_PME: begin
          if (pme_clear) begin
            state_r <= S_REMOVE;
          end
        end
        S_REMOVE: state_r <= S_DEVICE_NUMBER_FIELD;
        S_DEVICE_NUMBER_FIELD: state_r <= S_ADD;
        S_ADD: begin
          cnt_r   <= '0;
          state_r <= S_ACTION;
        end
        S_ACTION: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= act_len - 1'b1) begin
            state_r <= S_DONE;
          end
        end
        S_DONE: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // per-port state and control registers
  // ****************************************
  genvar i, p, k;
  generate
    for (i = 0; i < NPORT; i++) begin : g_port
      wire me      = (cur_r == IW'(i));
      wire wr_me   = wr_idx_r == IW'(i);
      // hardware set wins over a same-cycle write-one-to-clear
      wire st_set  = take & (pick == IW'(i));
      wire dn_set  = (state_r == S_DONE) & me;
      wire st_clr  = wr_st & wr_me & hwdata[STS_START];
      wire dn_clr  = wr_st & wr_me & hwdata[STS_DONE];
      wire pd_set  = wr_ctl & wr_me & ctl_diff;

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          ctl_r[i]     <= CTL_RST;
          started_r[i] <= 1'b0;
          done_r[i]    <= 1'b0;
          pend_r[i]    <= 1'b0;
          att_r[i]     <= 1'b0;
          mode_r[i]    <= PMCP_UNATT;
          part_r[i]    <= '0;
          device_number_field_r[i]  <= '0;
        end else begin
          if (wr_ctl & wr_me) begin
            ctl_r[i] <= hwdata;
          end
          started_r[i] <= st_set | (started_r[i] & ~st_clr);
          done_r[i]    <= dn_set | (done_r[i] & ~dn_clr);
          pend_r[i]    <= pd_set | (pend_r[i] & ~st_set);
          if (removing & me) begin
            att_r[i] <= 1'b0;
          end
          if ((state_r == S_DEVICE_NUMBER_FIELD) & me) begin
            device_number_field_r[i] <= cur_ctl[DEV_LSB +: DEV_W];
          end
          if ((state_r == S_ADD) & me) begin
            mode_r[i] <= new_mode;
            part_r[i] <= new_part;
            att_r[i]  <= new_att;
          end
        end
      end
      assign dev_num[DEV_W*i +: DEV_W] = device_number_field_r[i];
    end
  endgenerate

  // ****************************************
  // partition membership and aggregation
  // ****************************************
  logic [NPORT-1:0] upm  [NPART];
  logic [NPORT-1:0] dnm  [NPART];
  logic [NPORT-1:0] ixk  [4];
  logic [3:0]       agg  [NPART];
  logic [NPART-1:0] hot_p;
  logic [NPART-1:0] sbr_p;
  logic [NPART-1:0] dsx_p;
  logic [NPART-1:0] usx_p;
  logic [NPART-1:0] all_l1_p;
  logic [NPART-1:0] lock_nxt;

  generate
    for (i = 0; i < NPORT; i++) begin : g_ix
      for (k = 0; k < 4; k++) begin : g_k
        assign ixk[k][i] = intx_s[4*i+k];
      end
    end
    for (p = 0; p < NPART; p++) begin : g_part
      for (i = 0; i < NPORT; i++) begin : g_m
        wire in_p = att_r[i] & (part_r[i] == PSEL_W'(p));
        assign upm[p][i] = in_p & (mode_r[i] == PMCP_UP);
        assign dnm[p][i] = in_p & (mode_r[i] == PMCP_DOWN);
      end
      // only attached upstream ports drive the partition resets
      assign hot_p[p]    = |(upm[p] & (hot_s | dld_s));
      assign sbr_p[p]    = |(upm[p] & secondary_reset_bit);
      assign dsx_p[p]    = |(dnm[p] & rxx_s);
      assign usx_p[p]    = |(upm[p] & rxx_s);
      assign all_l1_p[p] = &(~dnm[p] | l1_s);
      for (k = 0; k < 4; k++) begin : g_agg
        assign agg[p][k] = |(dnm[p] & ixk[k]);
      end
      wire rm_here  = removing & cur_att & (part_r[cur_r] == PSEL_W'(p));
      wire rm_unl   = rm_here & (cur_up | lock_port_r[cur_r]);
      wire lk_set   = |(lock_set & (upm[p] | dnm[p]));
      assign lock_nxt[p] = lk_set | (lock_r[p] & ~lock_release[p] & ~rm_unl);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_r         <= '0;
      part_hot_reset <= '0;
      part_sbr       <= '0;
      part_locked    <= '0;
    end else begin
      lock_r         <= lock_nxt;
      part_hot_reset <= hot_p;
      part_sbr       <= sbr_p;
      part_locked    <= lock_nxt;
    end
  end

  // ****************************************
  // per-port partition effects
  // ****************************************
  generate
    for (i = 0; i < NPORT; i++) begin : g_eff
      wire [PSEL_W-1:0] pp   = part_r[i];
      wire              isup = att_r[i] & (mode_r[i] == PMCP_UP);
      wire              isdn = att_r[i] & (mode_r[i] == PMCP_DOWN);
      // membership gates every effect except the action reset, so removal and addition switch cleanly
      wire rst_n  = (att_r[i] & (hot_p[pp] | sbr_p[pp]))
                  | (isdn & secondary_reset_bit[i]);
      wire l0s_n  = (isup & dsx_p[pp]) | (isdn & usx_p[pp]);
      wire l1_n   = isup & all_l1_p[pp];
      wire lkp_n  = (lock_set[i] & att_r[i])
                  | (lock_port_r[i] & att_r[i] & lock_nxt[pp]
                     & ~(removing & (cur_r == IW'(i))));
      wire act_n  = (state_r == S_ACTION) & (cur_r == IW'(i)) & act_r;

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          port_in_reset[i]    <= 1'b0;
          route_valid[i]      <= 1'b0;
          l0s_exit_req[i]     <= 1'b0;
          l1_entry_ok[i]      <= 1'b0;
          pme_member[i]       <= 1'b0;
          intx_up[4*i +: 4]   <= 4'h0;
          port_act_reset[i]   <= 1'b0;
          lock_port_r[i]      <= 1'b0;
        end else begin
          port_in_reset[i]    <= rst_n;
          route_valid[i]      <= att_r[i];
          l0s_exit_req[i]     <= l0s_n;
          l1_entry_ok[i]      <= l1_n;
          pme_member[i]       <= att_r[i];
          intx_up[4*i +: 4]   <= isup ? agg[pp] : 4'h0;
          port_act_reset[i]   <= act_n;
          lock_port_r[i]      <= lkp_n;
        end
      end
    end
  endgenerate

  // traffic through a changing port is assumed quiesced by software
  // nothing here blocks or drains packets during a change

endmodule

// ### hdl/pmcp_pkg.sv
package pmcp_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_NS      = 8;
  localparam int unsigned T_NONE_NS   = 2000000;
  localparam int unsigned T_RST_NS    = 2500000;
  localparam int unsigned LAT_NONE    = T_NONE_NS / CLK_NS;
  localparam int unsigned LAT_RST     = T_RST_NS / CLK_NS;
  // cycles kept free for the sequencer steps around the action hold
  localparam int unsigned LAT_MARGIN  = 16;
  localparam int unsigned CNT_W       = 19;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned PORT_STRIDE = 8;
  localparam int unsigned CTL_OFS     = 0;
  localparam int unsigned STS_OFS     = 4;
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned MODE_W      = 2;
  localparam int unsigned PSEL_LSB    = 4;
  localparam int unsigned PSEL_W      = 2;
  localparam int unsigned DEV_LSB     = 8;
  localparam int unsigned DEV_W       = 5;
  localparam int unsigned ACT_BIT     = 16;
  localparam int unsigned STS_START   = 0;
  localparam int unsigned STS_DONE    = 1;
  localparam int unsigned STS_BUSY    = 2;
  localparam logic [31:0] CTL_RST     = 32'h0000_0000;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;
  localparam int unsigned NSYNC       = 13;

  typedef enum logic [1:0] {
    PMCP_UNATT,
    PMCP_UP,
    PMCP_DOWN,
    PMCP_DIS
  } pmcp_mode_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_PME,
    S_REMOVE,
    S_DEVICE_NUMBER_FIELD,
    S_ADD,
    S_ACTION,
    S_DONE
  } pmcp_state_t;

endpackage

// ### tb/pmcp_mode_change_checker.sv
module pmcp_mode_change_checker #(
  parameter int unsigned NPORT = 4,
  parameter int unsigned NPART = 4
) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire logic [NPORT-1:0]   ts1_hot_reset,
  input wire logic [NPORT-1:0]   dl_down,
  input wire logic [NPORT-1:0]   rx_l0s_exit,
  input wire logic [4*NPORT-1:0] intx_in,
  input wire logic [NPORT-1:0]   secondary_reset_bit,
  input wire logic [NPORT-1:0]   route_valid,
  input wire logic [NPORT-1:0]   pme_member,
  input wire logic [NPORT-1:0]   l0s_exit_req,
  input wire logic [4*NPORT-1:0] intx_up,
  input wire logic [NPART-1:0]   part_hot_reset,
  input wire logic [NPART-1:0]   part_sbr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ****************
  // properties
  // ****************
  // link inputs pass 2 sync flops and an output flop: 3 cycles
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait OKAY");
  a_rdata_idle: assert property (hrdata != 32'h0 |->
    $past(hsel && htrans[1] && !hwrite && hready))
    else $error("read data outside a read data phase");
  a_reset_clear: assert property ($fell(sys_rst) |->
    route_valid == '0 && part_hot_reset == '0 && intx_up == '0 && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
  a_route_member: assert property (route_valid == pme_member)
    else $error("route and pme membership disagree");
  a_intx_cause: assert property (intx_up != '0 |-> $past(intx_in != '0, 3))
    else $error("intx raised without a source");
  a_l0s_cause: assert property (l0s_exit_req != '0 |-> $past(rx_l0s_exit != '0, 3))
    else $error("l0s exit without a receiver exit");
  a_hot_cause: assert property (part_hot_reset != '0 |->
    $past((ts1_hot_reset | dl_down) != '0, 3))
    else $error("partition hot reset without a cause");
  a_sbr_cause: assert property (part_sbr != '0 |->
    $past(secondary_reset_bit != '0) || $past(secondary_reset_bit != '0, 2))
    else $error("bus reset without a secondary reset bit");
endmodule

bind pmcp_mode_change pmcp_mode_change_checker #(.NPORT(NPORT), .NPART(NPART)) chk_u (
  .clk, .sys_rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .ts1_hot_reset, .dl_down, .rx_l0s_exit, .intx_in, .secondary_reset_bit, .route_valid,
  .pme_member, .l0s_exit_req, .intx_up, .part_hot_reset, .part_sbr
);

// ### tb/pmcp_pme_model.sv
module pmcp_pme_model #(
  parameter int unsigned NPORT = 4,
  parameter int          DLY   = 120,
  parameter int          HOLD  = 200
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [NPORT-1:0] pme_start,
  input  wire logic [1:0]       pme_how,
  output logic      [NPORT-1:0] pme_sync_busy,
  output logic      [NPORT-1:0] pme_ack_all,
  output logic      [NPORT-1:0] pme_abandon,
  output logic      [NPORT-1:0] pme_ack_seen,
  output logic      [NPORT-1:0] pme_ack_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [NPORT];

  // ****************
  // sync partner
  // ****************
  // busy outlives completion, so a design waiting on busy alone finishes late
  always @(posedge clk) begin
    for (int i = 0; i < NPORT; i++) begin
      {pme_ack_timeout[i], pme_ack_seen[i], pme_abandon[i], pme_ack_all[i]} <= 4'h0;
      if (sys_rst) begin
        pme_sync_busy[i] <= 1'b0;
        cnt[i] <= 0;
      end else if (pme_start[i]) begin
        pme_sync_busy[i] <= 1'b1;
        cnt[i] <= DLY + HOLD;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
        pme_sync_busy[i] <= (cnt[i] > 1);
        if (cnt[i] == HOLD) begin
          {pme_ack_timeout[i], pme_ack_seen[i], pme_abandon[i], pme_ack_all[i]}
            <= 4'h1 << pme_how;
        end
      end
    end
  end
endmodule

// ### tb/tb_top.sv
module tb_top
  import pmcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LNONE = 64;
  localparam int LRST  = 80;
  localparam int DLY   = 120;
  typedef struct packed {
    logic [1:0]  p;
    logic [31:0] ctl;
    logic [3:0]  route;
    logic [4:0]  dev;
  } pmcp_row_t;
  logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans, pme_how;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [3:0]  ts1_hot_reset, dl_down, rx_l0s_exit, in_l1, secondary_reset_bit, lock_set;
  logic [3:0]  lock_release, pme_sync_busy, pme_ack_all, pme_abandon, pme_ack_seen;
  logic [3:0]  pme_ack_timeout, pme_start, port_in_reset, route_valid, l0s_exit_req;
  logic [3:0]  l1_entry_ok, pme_member, port_act_reset, part_hot_reset, part_sbr, part_locked;
  logic [15:0] intx_in, intx_up;
  logic [19:0] dev_num;
  int          mismatches = 0, samples_checked = 0, cycles = 0, n;
  wire         hready = hreadyout;
  pmcp_row_t   rows [7] = '{
    '{2'd0, 32'h0000_0001, 4'h1, 5'h00},
    '{2'd1, 32'h0000_0302, 4'h3, 5'h03},
    '{2'd2, 32'h0000_0402, 4'h7, 5'h04},
    '{2'd1, 32'h0000_0502, 4'h7, 5'h05},
    '{2'd3, 32'h0001_0031, 4'hf, 5'h00},
    '{2'd2, 32'h0000_0003, 4'hb, 5'h00},
    '{2'd2, 32'h0000_0012, 4'hf, 5'h00}
  };

  pmcp_mode_change #(.LAT_NONE_CYC(LNONE), .LAT_RST_CYC(LRST)) dut_u (
    .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .ts1_hot_reset, .dl_down, .rx_l0s_exit, .in_l1, .pme_sync_busy,
    .pme_ack_all, .pme_abandon, .pme_ack_seen, .pme_ack_timeout, .intx_in,
    .secondary_reset_bit, .lock_set, .lock_release, .port_in_reset, .route_valid,
    .l0s_exit_req, .l1_entry_ok, .pme_member, .intx_up, .port_act_reset, .dev_num,
    .part_hot_reset, .part_sbr, .part_locked
  );
  pmcp_pme_model #(.DLY(DLY)) pme_u (
    .clk, .sys_rst, .pme_start, .pme_how, .pme_sync_busy, .pme_ack_all, .pme_abandon,
    .pme_ack_seen, .pme_ack_timeout
  );

  // ****************
  // helpers
  // ****************
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(d, exp);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  // link stimulus held still while a change runs
  task automatic change(input int p, input logic [31:0] c, input int lat);
    logic [3:0] act;
    act = 4'h0;
    xfer(1'b1, 8 * p, c);
    @(posedge clk);
    rd_chk(8 * p + 4, 32'h5);
    n = 3;
    while (d[STS_DONE] !== 1'b1 && n < lat) begin
      xfer(1'b0, 8 * p + 4, 32'h0);
      act |= port_act_reset;
      n += 2;
    end
    chk(d, 32'h3);
    chk(act, c[ACT_BIT] ? 4'(1 << p) : 4'h0);
    xfer(1'b1, 8 * p + 4, 32'h3);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // bound well above the slowest path of about 2200 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // ****************
  // sequence
  // ****************
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, hsize, ts1_hot_reset, dl_down} = '0;
    {rx_l0s_exit, in_l1, intx_in, secondary_reset_bit, lock_set, lock_release} = '0;
    {pme_start, pme_how} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      change(rows[i].p, rows[i].ctl, rows[i].ctl[ACT_BIT] ? LRST : LNONE);
      chk(route_valid, rows[i].route);
      chk(dev_num[rows[i].p * DEV_W +: DEV_W], rows[i].dev);
      rd_chk(rows[i].p * 8, rows[i].ctl);
    end
    xfer(1'b1, 32'h8, 32'h0000_0502);
    settle();
    rd_chk(32'hc, 32'h0);
    rd_chk(32'h40, 32'h0);
    rx_l0s_exit <= 4'h2;
    settle();
    chk(l0s_exit_req, 4'h1);
    rx_l0s_exit <= 4'h1;
    settle();
    chk(l0s_exit_req, 4'h2);
    in_l1 <= 4'h2;
    settle();
    chk(l1_entry_ok[0], 1'b1);
    in_l1 <= 4'h0;
    intx_in <= 16'h00f0;
    rx_l0s_exit <= 4'h2;
    settle();
    chk(l1_entry_ok[0], 1'b0);
    chk(intx_up, 16'h000f);
    change(1, 32'h0, LNONE);
    chk(intx_up, 16'h0);
    chk(l0s_exit_req, 4'h0);
    {intx_in, rx_l0s_exit} <= '0;
    change(1, 32'h502, LNONE);
    change(2, 32'h402, LNONE);
    lock_set <= 4'h2;
    @(posedge clk);
    lock_set <= 4'h0;
    settle();
    chk(part_locked, 4'h1);
    change(2, 32'h0, LNONE);
    chk(part_locked, 4'h1);
    change(1, 32'h0, LNONE);
    chk(part_locked, 4'h0);
    change(1, 32'h502, LNONE);
    lock_set <= 4'h2;
    @(posedge clk);
    lock_set <= 4'h0;
    change(0, 32'h0, LNONE);
    chk(part_locked, 4'h0);
    chk(route_valid, 4'ha);
    ts1_hot_reset <= 4'h1;
    change(0, 32'h1, LNONE);
    settle();
    chk(part_hot_reset, 4'h1);
    chk(port_in_reset[1], 1'b1);
    change(1, 32'h0, LNONE);
    chk({port_in_reset[1], part_hot_reset}, 5'h01);
    change(1, 32'h502, LNONE);
    settle();
    chk(port_in_reset[1], 1'b1);
    change(0, 32'h0, LNONE);
    chk(part_hot_reset, 4'h0);
    ts1_hot_reset <= 4'h0;
    change(0, 32'h1, LNONE);
    secondary_reset_bit <= 4'h1;
    settle();
    chk(part_sbr, 4'h1);
    change(0, 32'h0, LNONE);
    chk(part_sbr, 4'h0);
    secondary_reset_bit <= 4'h2;
    settle();
    chk({port_in_reset[1], part_sbr}, 5'h10);
    secondary_reset_bit <= 4'h0;
    change(0, 32'h1, LNONE);
    // one completion kind per pass: ack, abandon, ack seen, ack timer
    for (int k = 0; k < 4; k++) begin
      pme_how <= 2'(k);
      pme_start[k / 2] <= 1'b1;
      @(posedge clk);
      pme_start <= '0;
      settle();
      change(k / 2, ((k + 1) << 8) | (k < 2 ? 1 : 2), LNONE + DLY + 16);
      chk(n > DLY - 8, 1'b1);
    end
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(route_valid, 4'h0);
    rd_chk(32'h0, 32'h0);
    test_done();
  end
endmodule
